/* File: peum_pkg.sv */
// Constants for the upper port E pin multiplexer: register map, fields, resets.
package peum_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] PEUM_OFF_PIN_LEVEL = 8'h00;
   localparam logic [7:0] PEUM_OFF_OUTPUT_LATCH = 8'h04;
   localparam logic [7:0] PEUM_OFF_DIRECTION = 8'h08;
   localparam logic [7:0] PEUM_OFF_PORT_A_LATCH = 8'h0C;
   localparam logic [7:0] PEUM_OFF_CONFIG = 8'h10;
   localparam logic [7:0] PEUM_OFF_STATUS = 8'h14;

   // Port E bit positions handled here
   localparam int PEUM_LOW_BIT = 5;
   localparam int PEUM_NPINS = 3;

   // Port A latch register fields
   localparam int PEUM_PA_PORT_D_PU_BIT = 7;
   localparam int PEUM_PA_PORT_E_PU_BIT = 6;

   // Configuration register fields
   localparam int PEUM_CFG_VARIANT_LSB = 0;
   localparam int PEUM_CFG_PWM_REMAP_BIT = 2;
   localparam int PEUM_CFG_UNIT2_SEL_BIT = 3;
   localparam int PEUM_CFG_MCU_MODE_BIT = 4;
   localparam int PEUM_CFG_TRI_CHAN_C_BIT = 5;
   localparam int PEUM_CFG_TRI_CHAN_B_BIT = 6;
   localparam int PEUM_CFG_TRI_CHAN_A_BIT = 7;

   // Status register fields
   localparam int PEUM_ST_MEMBUS_DATA_LSB = 0;
   localparam int PEUM_ST_MEMBUS_EN_BIT = 3;

   // Reset values
   localparam logic [7:0] PEUM_RST_LATCH = 8'h00;
   localparam logic [7:0] PEUM_RST_DIRECTION = 8'hFF;
   localparam logic [7:0] PEUM_RST_PORT_A = 8'h00;
   localparam logic [7:0] PEUM_RST_CONFIG = 8'h1E;

   // AXI responses
   localparam logic [1:0] PEUM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PEUM_RESP_SLVERR = 2'h2;

   // Package variant encoding
   typedef enum logic [1:0] {
      PEUM_PKG_64 = 2'b00,
      PEUM_PKG_80 = 2'b01,
      PEUM_PKG_100 = 2'b10
   } peum_variant_e;

endpackage

/* File: peum_sync.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module peum_sync #(
   parameter int WIDTH = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_r; // First stage, read only by the second
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] out_nxt;

   // A zero-width chain has nothing to carry; refuse it while elaborating
   if (WIDTH < 1) begin : g_width_bad
      $error("peum_sync: WIDTH must be at least 1");
   end

   // A bit changes only once stages two and three agree
   always_comb begin
      out_nxt = out_r;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            out_nxt[i] = s3_r[i];
         end
      end
   end

   // Synchronous reset to zero; chain shifts every cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign sync_out = out_r;
endmodule // peum_sync

/* File: peum_top.sv */
// Upper port E pins 5..7: registers over AXI4-Lite and pin function multiplexer.
`timescale 1ns/1ps
module peum_top
   import peum_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pads for port E bits 5..7 (index 0 is bit 5)
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   // External memory bus, same clock
   input wire logic external_memory_bus_active,
   input wire logic external_memory_bus_read,
   input wire logic [2:0] membus_addr_data_out,
   output logic [2:0] membus_data_in,
   // Enhanced PWM unit one
   input wire logic pwm_one_enable,
   input wire logic pwm_one_chan_c,
   input wire logic pwm_one_chan_b,
   input wire logic pwm_one_shutdown,
   // Capture/compare unit two
   input wire logic unit_two_enhanced,
   input wire logic pwm_two_chan_a,
   input wire logic pwm_two_shutdown,
   input wire logic unit_two_compare_en,
   input wire logic unit_two_compare_out,
   output logic unit_two_capture_in,
   // Port A latch and pull-up controls
   output logic [5:0] port_a_latch,
   output logic port_d_pullup_enable,
   output logic port_e_pullup_enable
);

   // Bits of the 8-bit port that this block implements
   function automatic logic [7:0] impl_mask(input logic [1:0] variant);
      begin
         // Bits 6 and 7 are absent on the smallest package
         if (variant == PEUM_PKG_64) begin
            impl_mask = 8'h20;
         end else begin
            impl_mask = 8'hE0;
         end
      end
   endfunction

   // Synchronised pad levels
   logic [2:0] pin_sync;

   peum_sync #(.WIDTH(PEUM_NPINS)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // Software registers
   logic [7:0] latch_r, latch_nxt; // Output latch
   logic [7:0] dir_r, dir_nxt; // Direction, one = input
   logic [7:0] pa_r, pa_nxt; // Port A latch with pull-ups
   logic [7:0] cfg_r, cfg_nxt; // Variant and routing configuration
   // Bus state
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic aw_have_r, aw_have_nxt;
   logic w_have_r, w_have_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt; // Only byte lane 0 holds data
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   // Pin drivers
   logic [2:0] pout_r, pout_nxt;
   logic [2:0] poe_r, poe_nxt;
   logic [2:0] mbin_r, mbin_nxt;
   logic cap_r, cap_nxt;

   // Decoded configuration
   logic [1:0] variant;
   logic [7:0] mask;
   logic membus_on;
   logic p1_routed;
   logic u2_routed;
   logic [2:0] dir3;
   logic [2:0] lat3;
   logic [7:0] pin_level;

   always_comb begin
      variant = cfg_r[PEUM_CFG_VARIANT_LSB +: 2];
      mask = impl_mask(variant);
      // Memory bus pins exist on the 100-pin part only
      membus_on = external_memory_bus_active && (variant == PEUM_PKG_100);
      // PWM one on pins 5/6 only with remap set on larger parts
      p1_routed = pwm_one_enable && cfg_r[PEUM_CFG_PWM_REMAP_BIT]
                  && (variant != PEUM_PKG_64);
      // Unit two on pin 7 only with select cleared, controller mode
      u2_routed = !cfg_r[PEUM_CFG_UNIT2_SEL_BIT] && cfg_r[PEUM_CFG_MCU_MODE_BIT]
                  && (variant != PEUM_PKG_64);
      dir3 = dir_r[7:PEUM_LOW_BIT];
      lat3 = latch_r[7:PEUM_LOW_BIT];
      // Pin-level reads show pads, absent bits zero
      pin_level = {pin_sync, 5'h00} & mask;
   end

   // Pin output multiplexer, one priority chain per pin
   always_comb begin
      pout_nxt = '0;
      poe_nxt = '0;
      for (int i = 0; i < PEUM_NPINS; i++) begin
         if (!mask[PEUM_LOW_BIT + i]) begin
            // Absent pad is never driven
            pout_nxt[i] = 1'b0;
            poe_nxt[i] = 1'b0;
         end else if (membus_on) begin
            // Memory bus wins regardless of direction
            pout_nxt[i] = membus_addr_data_out[i];
            poe_nxt[i] = !external_memory_bus_read;
         end else begin
            // Default: latch driven when direction is zero
            pout_nxt[i] = lat3[i];
            poe_nxt[i] = !dir3[i];
         end
      end
      if (mask[PEUM_LOW_BIT] && !membus_on && p1_routed && !dir3[0]) begin
         // Pin 5 carries channel C ahead of the latch
         pout_nxt[0] = pwm_one_chan_c;
         poe_nxt[0] = !(pwm_one_shutdown && cfg_r[PEUM_CFG_TRI_CHAN_C_BIT]);
      end
      if (mask[PEUM_LOW_BIT + 1] && !membus_on && p1_routed && !dir3[1]) begin
         // Pin 6 carries channel B ahead of the latch
         pout_nxt[1] = pwm_one_chan_b;
         poe_nxt[1] = !(pwm_one_shutdown && cfg_r[PEUM_CFG_TRI_CHAN_B_BIT]);
      end
      if (mask[PEUM_LOW_BIT + 2] && !membus_on && u2_routed && !dir3[2]) begin
         if (unit_two_enhanced) begin
            // Enhanced channel A, optional shutdown tri-state
            pout_nxt[2] = pwm_two_chan_a;
            poe_nxt[2] = !(pwm_two_shutdown && cfg_r[PEUM_CFG_TRI_CHAN_A_BIT]);
         end else if (unit_two_compare_en) begin
            // Compare or PWM output overrides port data
            pout_nxt[2] = unit_two_compare_out;
            poe_nxt[2] = 1'b1;
         end
      end
   end

   // Inputs to the memory bus and the capture unit
   always_comb begin
      // Captured whenever the bus reads, direction ignored
      mbin_nxt = mbin_r;
      if (membus_on && external_memory_bus_read) begin
         mbin_nxt = pin_sync & mask[7:PEUM_LOW_BIT];
      end
      // Capture input only when pin 7 is routed and an input
      cap_nxt = 1'b0;
      if (mask[7] && !membus_on && u2_routed && dir3[2]) begin
         cap_nxt = pin_sync[2];
      end
   end

   // AXI4-Lite write channel and register updates
   always_comb begin
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      latch_nxt = latch_r;
      dir_nxt = dir_r;
      pa_nxt = pa_r;
      cfg_nxt = cfg_r;
      // Address and data may come in either order
      if (s_axi_awvalid && awready_r) begin
         aw_have_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb0_nxt = s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      // Commit once both halves are held and no response is pending
      if (aw_have_r && w_have_r && !bvalid_r) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = PEUM_RESP_OKAY;
         case (waddr_r)
            // Writing the pin level writes the latch
            PEUM_OFF_PIN_LEVEL, PEUM_OFF_OUTPUT_LATCH: begin
               if (wstrb0_r) latch_nxt = wdata_r[7:0] & mask;
            end
            PEUM_OFF_DIRECTION: begin
               if (wstrb0_r) dir_nxt = (wdata_r[7:0] & mask) | ~mask;
            end
            PEUM_OFF_PORT_A_LATCH: begin
               if (wstrb0_r) pa_nxt = wdata_r[7:0];
            end
            PEUM_OFF_CONFIG: begin
               if (wstrb0_r) cfg_nxt = wdata_r[7:0];
            end
            PEUM_OFF_STATUS: begin
               bresp_nxt = PEUM_RESP_OKAY; // Read-only, write ignored
            end
            default: begin
               bresp_nxt = PEUM_RESP_SLVERR;
            end
         endcase
      end
      // Ready only while the slot for that half is empty
      awready_nxt = !aw_have_nxt;
      wready_nxt = !w_have_nxt;
   end

   // AXI4-Lite read channel
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = PEUM_RESP_OKAY;
         rdata_nxt = '0;
         case (s_axi_araddr)
            PEUM_OFF_PIN_LEVEL: rdata_nxt[7:0] = pin_level;
            PEUM_OFF_OUTPUT_LATCH: rdata_nxt[7:0] = latch_r & mask;
            PEUM_OFF_DIRECTION: rdata_nxt[7:0] = dir_r & mask;
            PEUM_OFF_PORT_A_LATCH: rdata_nxt[7:0] = pa_r;
            PEUM_OFF_CONFIG: rdata_nxt[7:0] = cfg_r;
            PEUM_OFF_STATUS: begin
               rdata_nxt[PEUM_ST_MEMBUS_DATA_LSB +: 3] = mbin_r;
               rdata_nxt[PEUM_ST_MEMBUS_EN_BIT] = membus_on;
            end
            default: begin
               rresp_nxt = PEUM_RESP_SLVERR;
            end
         endcase
      end
      // One read outstanding at a time
      arready_nxt = !rvalid_nxt;
   end

   // All state registered here; synchronous active-low reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_r <= PEUM_RST_LATCH;
         dir_r <= PEUM_RST_DIRECTION;
         pa_r <= PEUM_RST_PORT_A;
         cfg_r <= PEUM_RST_CONFIG;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= PEUM_RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= PEUM_RESP_OKAY;
         pout_r <= '0;
         poe_r <= '0;
         mbin_r <= '0;
         cap_r <= 1'b0;
      end else begin
         latch_r <= latch_nxt;
         dir_r <= dir_nxt;
         pa_r <= pa_nxt;
         cfg_r <= cfg_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         pout_r <= pout_nxt;
         poe_r <= poe_nxt;
         mbin_r <= mbin_nxt;
         cap_r <= cap_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign pin_out = pout_r;
   assign pin_oe = poe_r;
   assign membus_data_in = mbin_r;
   assign unit_two_capture_in = cap_r;
   assign port_a_latch = pa_r[5:0];
   assign port_d_pullup_enable = pa_r[PEUM_PA_PORT_D_PU_BIT];
   assign port_e_pullup_enable = pa_r[PEUM_PA_PORT_E_PU_BIT];
endmodule // peum_top

/* File: peum_asserts.sv */
// Checker for the bus handshake and memory-bus pin ownership of the port E pins.
`timescale 1ns/1ps
module peum_asserts
   import peum_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic external_memory_bus_active,
   input wire logic external_memory_bus_read,
   input wire logic [2:0] membus_addr_data_out
);
   logic [7:0] cfg_r; // Shadow of the config register
   logic [7:0] cfg_nxt; // Next shadow value
   logic mb_own; // Memory bus owns the pads this cycle
   // Shadow follows writes; the memory bus is kept idle around config writes
   always_comb begin
      cfg_nxt = cfg_r;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr == PEUM_OFF_CONFIG) begin
         cfg_nxt = s_axi_wdata[7:0];
      end
   end
   // Register the shadow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= PEUM_RST_CONFIG;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end
   assign mb_own = external_memory_bus_active
                   && cfg_r[PEUM_CFG_VARIANT_LSB +: 2] == PEUM_PKG_100;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_resp_lat_a: assert property (aw_w_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after acceptance");
   rd_resp_lat_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read data not one cycle after acceptance");
   wr_hold_a: assert property (aw_w_take |=> !s_axi_awready && !s_axi_wready)
      else $error("write address or data accepted before commit");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   unmapped_rd_a: assert property (ar_take and s_axi_araddr > 8'h14
      |=> s_axi_rresp == PEUM_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   mb_drive_a: assert property (mb_own && !external_memory_bus_read
      |=> pin_oe == 3'h7 && pin_out == $past(membus_addr_data_out))
      else $error("memory bus address not on pads");
   mb_read_a: assert property (mb_own && external_memory_bus_read |=> pin_oe == 3'h0)
      else $error("pads driven during memory bus read");
endmodule // peum_asserts
bind peum_top peum_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .pin_out(pin_out), .pin_oe(pin_oe),
   .external_memory_bus_active(external_memory_bus_active),
   .external_memory_bus_read(external_memory_bus_read),
   .membus_addr_data_out(membus_addr_data_out));

/* File: peum_partner.sv */
// Far-side model: memory device and loads sharing the three port E pads.
`timescale 1ns/1ps
module peum_partner (
   input wire logic aclk,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] drv_val,
   input wire logic drv_en,
   output logic [2:0] pin_in
);
   logic [2:0] last_r = 3'h0; // Last pad level; no pull, so a floating pad keeps flipping
   // Pad level: design driver first, then the far device, else floating
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (drv_en) begin
            pin_in[i] = drv_val[i];
         end else begin
            pin_in[i] = ~last_r[i];
         end
      end
   end
   // Remember the level so an undriven pad never looks steady
   always_ff @(posedge aclk) begin
      last_r <= pin_in;
   end
endmodule // peum_partner

/* File: tb_port_e_upper_pin_mux.sv */
// Self-checking bench for the upper port E pin multiplexer.
`timescale 1ns/1ps
module tb_port_e_upper_pin_mux;
   import peum_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, cap, pud, pue;
   logic mb_act, mb_rd, p1_en, p1_c, p1_b, p1_sd, u2_enh, p2_a, p2_sd, u2_cen, u2_cout, de;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [2:0] mb_ad, dv, pin_in, pin_out, pin_oe, mb_din;
   logic [5:0] pa;
   int n_fail = 0;
   int checks_done = 0;
   peum_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .external_memory_bus_active(mb_act),
      .external_memory_bus_read(mb_rd), .membus_addr_data_out(mb_ad), .membus_data_in(mb_din),
      .pwm_one_enable(p1_en), .pwm_one_chan_c(p1_c), .pwm_one_chan_b(p1_b),
      .pwm_one_shutdown(p1_sd), .unit_two_enhanced(u2_enh), .pwm_two_chan_a(p2_a),
      .pwm_two_shutdown(p2_sd), .unit_two_compare_en(u2_cen), .unit_two_compare_out(u2_cout),
      .unit_two_capture_in(cap), .port_a_latch(pa), .port_d_pullup_enable(pud),
      .port_e_pullup_enable(pue));
   peum_partner far_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .drv_val(dv),
      .drv_en(de), .pin_in(pin_in));
   // 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Let edges pass, then step off the edge so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // Pad enables, and pad levels only where driven
   task automatic pins(input logic [2:0] oe, input logic [2:0] po);
      chk({29'h0, pin_oe}, {29'h0, oe});
      chk({29'h0, pin_out & oe}, {29'h0, po});
   endtask
   // Bus write: address and data offered together, each held until taken
   // No cycle count is assumed; only the watchdog ends a wait that hangs
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do begin
         @(posedge aclk);
      end while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, PEUM_RESP_OKAY});
   endtask
   // Bus read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!arready);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // Verdict and end of run
   task automatic conclude();
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the 140 or so cycles the tests take
   initial begin
      #100000;
      n_fail++;
      conclude();
   end
   // Test sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, mb_act, mb_rd, p1_en, p1_c} = '0;
      {p1_b, p1_sd, u2_enh, p2_a, p2_sd, u2_cen, u2_cout, de} = '0;
      {awaddr, araddr, wdata, mb_ad, dv} = '0;
      wstrb = 4'hF;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(PEUM_OFF_DIRECTION, 32'hE0, PEUM_RESP_OKAY);
      rd(PEUM_OFF_CONFIG, 32'h1E, PEUM_RESP_OKAY);
      rd(PEUM_OFF_PORT_A_LATCH, 32'h0, PEUM_RESP_OKAY);
      rd(8'h18, 32'h0, PEUM_RESP_SLVERR);
      // Port A latch bits and the two pull-up enables
      wr(PEUM_OFF_PORT_A_LATCH, 8'h95);
      chk({26'h0, pa}, 32'h15);
      chk({30'h0, pud, pue}, 32'h2);
      rd(PEUM_OFF_PORT_A_LATCH, 32'h95, PEUM_RESP_OKAY);
      // Inputs read through the pin level register
      @(posedge aclk);
      dv <= 3'b011;
      de <= 1'b1;
      cyc(6);
      rd(PEUM_OFF_PIN_LEVEL, 32'h60, PEUM_RESP_OKAY);
      wr(PEUM_OFF_OUTPUT_LATCH, 8'hA0);
      wr(PEUM_OFF_DIRECTION, 8'h00);
      cyc(2);
      pins(3'h7, 3'b101);
      // PWM unit one takes pins 5 and 6 over the latch
      p1_en <= 1'b1;
      p1_b <= 1'b1;
      cyc(2);
      pins(3'h7, 3'b110);
      wr(PEUM_OFF_CONFIG, 8'h7E);
      p1_sd <= 1'b1;
      cyc(2);
      pins(3'b100, 3'b100);
      p1_sd <= 1'b0;
      wr(PEUM_OFF_CONFIG, 8'h1A);
      cyc(2);
      pins(3'h7, 3'b101);
      // Memory bus outranks PWM and ignores direction
      wr(PEUM_OFF_CONFIG, 8'h1E);
      mb_ad <= 3'b010;
      mb_act <= 1'b1;
      cyc(2);
      pins(3'h7, 3'b010);
      wr(PEUM_OFF_DIRECTION, 8'hFF);
      cyc(2);
      pins(3'h7, 3'b010);
      mb_rd <= 1'b1;
      dv <= 3'b101;
      cyc(6);
      chk({29'h0, mb_din}, 32'h5);
      pins(3'h0, 3'h0);
      rd(PEUM_OFF_STATUS, 32'hD, PEUM_RESP_OKAY);
      // No memory bus on the 80-pin variant
      mb_act <= 1'b0;
      mb_rd <= 1'b0;
      wr(PEUM_OFF_CONFIG, 8'h1D);
      mb_act <= 1'b1;
      cyc(2);
      pins(3'h0, 3'h0);
      // Unit two on pin 7: compare, channel A, capture
      mb_act <= 1'b0;
      p1_en <= 1'b0;
      wr(PEUM_OFF_CONFIG, 8'h16);
      wr(PEUM_OFF_OUTPUT_LATCH, 8'h00);
      wr(PEUM_OFF_DIRECTION, 8'h00);
      u2_cen <= 1'b1;
      u2_cout <= 1'b1;
      cyc(2);
      pins(3'h7, 3'b100);
      u2_enh <= 1'b1;
      p2_a <= 1'b1;
      u2_cout <= 1'b0;
      cyc(2);
      pins(3'h7, 3'b100);
      // Channel A tri-states in shutdown once its enable bit is set
      wr(PEUM_OFF_CONFIG, 8'h96);
      p2_sd <= 1'b1;
      cyc(2);
      pins(3'b011, 3'b000);
      p2_sd <= 1'b0;
      wr(PEUM_OFF_DIRECTION, 8'hFF);
      dv <= 3'b100;
      cyc(6);
      chk({31'h0, cap}, 32'h1);
      wr(PEUM_OFF_DIRECTION, 8'h00);
      wr(PEUM_OFF_CONFIG, 8'h1E);
      cyc(2);
      pins(3'h7, 3'b000);
      // Smallest package: bits 6 and 7 absent
      wr(PEUM_OFF_CONFIG, 8'h1C);
      wr(PEUM_OFF_OUTPUT_LATCH, 8'hE0);
      rd(PEUM_OFF_OUTPUT_LATCH, 32'h20, PEUM_RESP_OKAY);
      cyc(2);
      pins(3'b001, 3'b001);
      conclude();
   end
endmodule // tb_port_e_upper_pin_mux
